/* hw/capture_compare_unit.sv */
// Purpose: capture sync, match detection and output pin of one module
// Assumes: mode, value and counter come from registers of clk_sys
// Notes: events are one-cycle pulses on a rising condition
`timescale 1ns/100ps
module capture_compare_unit
    import counter_array_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // capture input pin
    input wire logic cap_in,
    // register core link
    module_cfg_if.unit cfg
);
    logic sync1_q, sync2_q, sync3_q;
    logic eq_full_q, eq_low_q, wrap_q, pin_q;
    logic eq_full_d, eq_low_d, wrap_d, pin_d;
    logic wide, ecom, pwm, tog, freq;
    logic [15:0] mask;

    function automatic logic [15:0] cycle_mask(input logic [1:0] sel);
        logic [16:0] one;
        one = 17'h00001 << (CYCLE_BASE_BITS + int'(sel));
        return 16'(one - 17'h00001);
    endfunction : cycle_mask

    assign wide = cfg.mode[BIT_WIDE_PULSE];
    assign ecom = cfg.mode[BIT_COMPARE_EN];
    assign pwm = cfg.mode[BIT_PULSE_WIDTH];
    assign tog = cfg.mode[BIT_TOGGLE];
    assign freq = pwm && tog;
    assign mask = cycle_mask(cfg.cycle_len);

    // two-stage sync, third stage for edge detect
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end else begin
            sync1_q <= cap_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    assign cfg.cap_pulse =
        (cfg.mode[BIT_RISE_CAP] && sync2_q && !sync3_q) ||
        (cfg.mode[BIT_FALL_CAP] && !sync2_q && sync3_q);

    always_comb begin
        eq_full_d = ecom && (cfg.counter == cfg.value);
        eq_low_d = ecom && (cfg.counter[7:0] == cfg.value[7:0]);
        wrap_d = pwm && !wide && ((cfg.counter & mask) == 16'h0000);
        pin_d = pin_q;
        if (freq) begin
            if (eq_low_d && !eq_low_q) begin
                pin_d = !pin_q;
            end
        end else if (pwm) begin
            if (!ecom) begin
                pin_d = 1'b0;
            end else if (wide) begin
                pin_d = cfg.counter >= cfg.value;
            end else begin
                pin_d = (cfg.counter & mask) >= (cfg.value & mask);
            end
        end else if (tog && eq_full_d && !eq_full_q) begin
            pin_d = !pin_q;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            eq_full_q <= 1'b0;
            eq_low_q <= 1'b0;
            wrap_q <= 1'b0;
            pin_q <= 1'b0;
        end else begin
            eq_full_q <= eq_full_d;
            eq_low_q <= eq_low_d;
            wrap_q <= wrap_d;
            pin_q <= pin_d;
        end
    end

    assign cfg.match_pulse = eq_full_d && !eq_full_q;
    assign cfg.freq_step = freq && eq_low_d && !eq_low_q;
    assign cfg.wrap_pulse = wrap_d && !wrap_q && !freq;
    assign cfg.pin = pin_q;
endmodule : capture_compare_unit

/* hw/counter_array_module_mode_ctrl.sv */
// Purpose: mode registers, shared counter and module values
// Assumes: register port and count_tick are on clk_sys
// Notes: read data appears one cycle after the read strobe
`timescale 1ns/100ps
module counter_array_module_mode_ctrl
    import counter_array_pkg::*;
#(
    parameter int NUM_MODULES = 3
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // special function register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // counter time base
    input wire logic count_tick,
    // module pins
    input wire logic [NUM_MODULES-1:0] capture_in,
    output logic [NUM_MODULES-1:0] module_output_pin,
    // module events
    input wire logic [NUM_MODULES-1:0] event_flag_clr,
    output logic [NUM_MODULES-1:0] module_event_flag,
    output logic [NUM_MODULES-1:0] event_irq
);
    generate
        if (NUM_MODULES < 1 || NUM_MODULES > MAX_MODULES) begin : g_bad
            $error("module count outside the address map");
        end
    endgenerate

    logic [7:0] mode_q [NUM_MODULES];
    logic [7:0] mode_d [NUM_MODULES];
    logic [15:0] value_q [NUM_MODULES];
    logic [15:0] value_d [NUM_MODULES];
    logic [15:0] reload_q [NUM_MODULES];
    logic [15:0] reload_d [NUM_MODULES];
    logic [NUM_MODULES-1:0] flag_q, flag_d;
    logic [15:0] counter_q, counter_d;
    logic [7:0] snap_q, snap_d;
    logic view_q, view_d;
    logic [1:0] cycle_length_select_q, cycle_length_select_d;
    logic [7:0] rdata_q, rdata_d;
    logic [NUM_MODULES-1:0] cap_p, match_p, wrap_p, step_p;
    logic [NUM_MODULES-1:0] hit_mode, hit_lo, hit_hi;

    // one-hot address decode against a per-module table
    function automatic logic [NUM_MODULES-1:0] decode_slot(
        input logic [7:0] addr,
        input logic [7:0] tbl [MAX_MODULES]
    );
        logic [NUM_MODULES-1:0] hit;
        hit = '0;
        for (int k = 0; k < NUM_MODULES; k++) begin
            hit[k] = (addr == tbl[k]);
        end
        return hit;
    endfunction : decode_slot

    assign hit_mode = decode_slot(sfr_addr, ADDR_MODE);
    assign hit_lo = decode_slot(sfr_addr, ADDR_VALUE_LOW);
    assign hit_hi = decode_slot(sfr_addr, ADDR_VALUE_HIGH);

    generate
        for (genvar i = 0; i < NUM_MODULES; i++) begin : g_mod
            module_cfg_if link ();
            assign link.mode = mode_q[i];
            assign link.value = value_q[i];
            assign link.counter = counter_q;
            assign link.cycle_len = cycle_length_select_q;
            assign cap_p[i] = link.cap_pulse;
            assign match_p[i] = link.match_pulse;
            assign wrap_p[i] = link.wrap_pulse;
            assign step_p[i] = link.freq_step;
            assign module_output_pin[i] = link.pin;

            capture_compare_unit u_unit (
                .clk_sys(clk_sys),
                .rstn(rstn),
                .cap_in(capture_in[i]),
                .cfg(link.unit)
            );
        end
    endgenerate

    // counter, snapshot and configuration
    always_comb begin
        counter_d = counter_q;
        snap_d = snap_q;
        view_d = view_q;
        cycle_length_select_d = cycle_length_select_q;
        if (count_tick) begin
            counter_d = 16'(counter_q + 16'h0001);
        end
        if (sfr_wr && sfr_addr == ADDR_COUNTER_LOW) begin
            counter_d[7:0] = sfr_wdata;
        end
        if (sfr_wr && sfr_addr == ADDR_COUNTER_HIGH) begin
            counter_d[15:8] = sfr_wdata;
        end
        if (sfr_rd && sfr_addr == ADDR_COUNTER_LOW) begin
            snap_d = counter_q[15:8];
        end
        if (sfr_wr && sfr_addr == ADDR_PWM_CONFIG) begin
            view_d = sfr_wdata[BIT_RELOAD_VIEW];
            cycle_length_select_d = sfr_wdata[CYCLE_SEL_LSB +: CYCLE_SEL_W];
        end
    end

    // per-module mode, value, reload and flag
    always_comb begin
        for (int i = 0; i < NUM_MODULES; i++) begin
            mode_d[i] = mode_q[i];
            value_d[i] = value_q[i];
            reload_d[i] = reload_q[i];
            flag_d[i] = flag_q[i];
            if (wrap_p[i]) begin
                if (cycle_length_select_q == 2'b00) begin
                    value_d[i][7:0] = value_q[i][15:8];
                end else begin
                    value_d[i] = reload_q[i];
                end
            end
            if (step_p[i]) begin
                value_d[i][7:0] = 8'(value_q[i][7:0] + value_q[i][15:8]);
            end
            if (cap_p[i]) begin
                value_d[i] = counter_q;
            end
            if (sfr_wr && hit_mode[i]) begin
                mode_d[i] = sfr_wdata;
            end
            if (sfr_wr && hit_lo[i]) begin
                mode_d[i][BIT_COMPARE_EN] = 1'b0;
                if (view_q) begin
                    reload_d[i][7:0] = sfr_wdata;
                end else begin
                    value_d[i][7:0] = sfr_wdata;
                end
            end
            if (sfr_wr && hit_hi[i]) begin
                mode_d[i][BIT_COMPARE_EN] = 1'b1;
                if (view_q) begin
                    reload_d[i][15:8] = sfr_wdata;
                end else begin
                    value_d[i][15:8] = sfr_wdata;
                end
            end
            if (event_flag_clr[i]) begin
                flag_d[i] = 1'b0;
            end
            // set wins over a clear in the same cycle
            if (cap_p[i]) begin
                flag_d[i] = 1'b1;
            end
            if (match_p[i] && mode_q[i][BIT_MATCH_FLAG]) begin
                flag_d[i] = 1'b1;
            end
        end
    end

    // read mux, registered
    always_comb begin
        rdata_d = rdata_q;
        if (sfr_rd) begin
            rdata_d = READ_IDLE;
            if (sfr_addr == ADDR_COUNTER_LOW) begin
                rdata_d = counter_q[7:0];
            end
            if (sfr_addr == ADDR_COUNTER_HIGH) begin
                rdata_d = snap_q;
            end
            if (sfr_addr == ADDR_PWM_CONFIG) begin
                rdata_d[BIT_RELOAD_VIEW] = view_q;
                rdata_d[CYCLE_SEL_LSB +: CYCLE_SEL_W] = cycle_length_select_q;
            end
            for (int i = 0; i < NUM_MODULES; i++) begin
                if (hit_mode[i]) begin
                    rdata_d = mode_q[i];
                end
                if (hit_lo[i]) begin
                    rdata_d = view_q ? reload_q[i][7:0] : value_q[i][7:0];
                end
                if (hit_hi[i]) begin
                    rdata_d = view_q ? reload_q[i][15:8] : value_q[i][15:8];
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            counter_q <= COUNTER_RESET;
            snap_q <= 8'h00;
            view_q <= 1'b0;
            cycle_length_select_q <= 2'b00;
            rdata_q <= READ_IDLE;
            flag_q <= '0;
            for (int i = 0; i < NUM_MODULES; i++) begin
                mode_q[i] <= MODE_RESET;
                value_q[i] <= VALUE_RESET;
                reload_q[i] <= VALUE_RESET;
            end
        end else begin
            counter_q <= counter_d;
            snap_q <= snap_d;
            view_q <= view_d;
            cycle_length_select_q <= cycle_length_select_d;
            rdata_q <= rdata_d;
            flag_q <= flag_d;
            for (int i = 0; i < NUM_MODULES; i++) begin
                mode_q[i] <= mode_d[i];
                value_q[i] <= value_d[i];
                reload_q[i] <= reload_d[i];
            end
        end
    end

    assign sfr_rdata = rdata_q;
    assign module_event_flag = flag_q;
    always_comb begin
        for (int i = 0; i < NUM_MODULES; i++) begin
            event_irq[i] = flag_q[i] && mode_q[i][BIT_IRQ_EN];
        end
    end
endmodule : counter_array_module_mode_ctrl

/* shared/counter_array_pkg.sv */
// Purpose: constants for the counter array mode and counter logic
// Assumes: byte-wide special function register port, three modules
// Notes: per-module address tables are indexed by module number
package counter_array_pkg;
    localparam int MAX_MODULES = 3;
    localparam int CNT_W = 16;
    localparam int BYTE_W = 8;

    // register addresses
    localparam logic [7:0] ADDR_COUNTER_LOW = 8'hf9;
    localparam logic [7:0] ADDR_COUNTER_HIGH = 8'hfa;
    localparam logic [7:0] ADDR_PWM_CONFIG = 8'ha1;
    localparam logic [7:0] ADDR_MODE [MAX_MODULES] = '{8'hda, 8'hdb, 8'hdc};
    localparam logic [7:0] ADDR_VALUE_LOW [MAX_MODULES] =
        '{8'hfb, 8'he9, 8'heb};
    localparam logic [7:0] ADDR_VALUE_HIGH [MAX_MODULES] =
        '{8'hfc, 8'hea, 8'hec};

    // mode register fields
    localparam int BIT_WIDE_PULSE = 7;
    localparam int BIT_COMPARE_EN = 6;
    localparam int BIT_RISE_CAP = 5;
    localparam int BIT_FALL_CAP = 4;
    localparam int BIT_MATCH_FLAG = 3;
    localparam int BIT_TOGGLE = 2;
    localparam int BIT_PULSE_WIDTH = 1;
    localparam int BIT_IRQ_EN = 0;

    // pwm configuration fields
    localparam int BIT_RELOAD_VIEW = 7;
    localparam int CYCLE_SEL_LSB = 0;
    localparam int CYCLE_SEL_W = 2;
    localparam int CYCLE_BASE_BITS = 8;

    // reset values
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [15:0] COUNTER_RESET = 16'h0000;
    localparam logic [15:0] VALUE_RESET = 16'h0000;
    localparam logic [7:0] READ_IDLE = 8'h00;
endpackage : counter_array_pkg

/* shared/module_cfg_if.sv */
// Purpose: link between the register core and one module unit
// Assumes: single clock domain
// Notes: ctrl side owns mode, value, counter and cycle length, unit side reports events and its pin
`timescale 1ns/100ps
interface module_cfg_if;
    logic [7:0] mode;
    logic [15:0] value;
    logic [15:0] counter;
    logic [1:0] cycle_len;
    logic cap_pulse;
    logic match_pulse;
    logic wrap_pulse;
    logic freq_step;
    logic pin;

    modport ctrl (
        output mode, value, counter, cycle_len,
        input cap_pulse, match_pulse, wrap_pulse, freq_step, pin
    );
    modport unit (
        input mode, value, counter, cycle_len,
        output cap_pulse, match_pulse, wrap_pulse, freq_step, pin
    );
endinterface : module_cfg_if

/* tb/counter_array_module_mode_ctrl_tb.sv */
// Purpose: register level tests of the counter array mode control
// Assumes: cpu model drives the register port
// Notes: all inputs change at falling edges
`timescale 1ns/100ps
module counter_array_module_mode_ctrl_tb;
    import counter_array_pkg::*;
    logic clk_sys, rstn, count_tick;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic sfr_wr, sfr_rd;
    logic [2:0] capture_in, event_flag_clr, pin, flag, irq;
    int errors = 0;
    int check_count = 0;
    int n;
    logic p;
    logic [7:0] regs [5] = '{8'hda, 8'hdb, 8'hdc, 8'hf9, 8'hfa};
    logic [7:0] pcfg [5] = '{8'h00, 8'h00, 8'h01, 8'h02, 8'h03};
    logic [7:0] pmode [5] = '{8'hc2, 8'h42, 8'h42, 8'h42, 8'h42};
    logic [4:0] ppin = 5'b11001;

    cpu_sfr_model i_cpu (.clk_sys(clk_sys), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata));
    counter_array_module_mode_ctrl #(.NUM_MODULES(3)) i_dut (
        .clk_sys(clk_sys), .rstn(rstn), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .count_tick(count_tick),
        .capture_in(capture_in), .module_output_pin(pin),
        .event_flag_clr(event_flag_clr), .module_event_flag(flag),
        .event_irq(irq));

    task automatic wrap_up;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_cpu.rd(a, d);
        chk(d, exp);
    endtask : rchk

    task automatic setv(input int k, input logic [15:0] x);
        i_cpu.wr(ADDR_VALUE_LOW[k], x[7:0]);
        i_cpu.wr(ADDR_VALUE_HIGH[k], x[15:8]);
    endtask : setv

    task automatic setc(input logic [15:0] x);
        i_cpu.wr(ADDR_COUNTER_HIGH, x[15:8]);
        i_cpu.wr(ADDR_COUNTER_LOW, x[7:0]);
    endtask : setc

    task automatic ticks(input int t);
        @(negedge clk_sys);
        count_tick = 1'b1;
        repeat (t) @(negedge clk_sys);
        count_tick = 1'b0;
    endtask : ticks

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        #100us;
        errors++;
        wrap_up();
    end

    initial begin
        count_tick = 1'b0;
        capture_in = 3'h0;
        event_flag_clr = 3'h0;
        rstn = 1'b0;
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys);
        rstn = 1'b1;
        foreach (regs[i])
            rchk(regs[i], 8'h00);
        rchk(8'h00, 8'h00);
        for (int k = 0; k < 3; k++) begin
            i_cpu.wr(ADDR_MODE[k], 8'h35 + 8'(k));
            rchk(ADDR_MODE[k], 8'h35 + 8'(k));
        end
        // value byte writes move compare enable
        i_cpu.wr(ADDR_MODE[0], 8'h40);
        i_cpu.wr(ADDR_VALUE_LOW[0], 8'h11);
        rchk(ADDR_MODE[0], 8'h00);
        i_cpu.wr(ADDR_VALUE_HIGH[0], 8'h22);
        rchk(ADDR_MODE[0], 8'h40);
        i_cpu.wr(ADDR_PWM_CONFIG, 8'h80);
        i_cpu.wr(ADDR_VALUE_LOW[0], 8'h99);
        rchk(ADDR_VALUE_LOW[0], 8'h99);
        i_cpu.wr(ADDR_PWM_CONFIG, 8'h00);
        rchk(ADDR_VALUE_LOW[0], 8'h11);
        // counter bytes and high byte snapshot
        setc(16'h1234);
        rchk(ADDR_COUNTER_LOW, 8'h34);
        rchk(ADDR_COUNTER_HIGH, 8'h12);
        i_cpu.wr(ADDR_COUNTER_HIGH, 8'h56);
        rchk(ADDR_COUNTER_HIGH, 8'h12);
        rchk(ADDR_COUNTER_LOW, 8'h34);
        rchk(ADDR_COUNTER_HIGH, 8'h56);
        // capture on each edge with each arm bit
        for (int e = 0; e < 4; e++) begin
            i_cpu.wr(ADDR_MODE[0], (e < 2) ? 8'h20 : 8'h10);
            @(negedge clk_sys);
            capture_in[0] = ~capture_in[0];
            repeat (6) @(negedge clk_sys);
            chk(8'(flag[0]), 8'(e == 0 || e == 3));
            event_flag_clr[0] = 1'b1;
            @(negedge clk_sys);
            event_flag_clr[0] = 1'b0;
        end
        rchk(ADDR_VALUE_LOW[0], 8'h34);
        rchk(ADDR_VALUE_HIGH[0], 8'h56);
        ticks(5);
        rchk(ADDR_COUNTER_LOW, 8'h39);
        // match flag needs compare enable, irq needs its enable
        setv(1, 16'h0005);
        for (int m = 0; m < 2; m++) begin
            i_cpu.wr(ADDR_MODE[1], m ? 8'h49 : 8'h09);
            setc(16'h0000);
            ticks(10);
            chk(8'(flag[1]), 8'(m));
        end
        chk(8'(irq[1]), 8'h01);
        i_cpu.wr(ADDR_MODE[1], 8'h48);
        chk(8'(irq[1]), 8'h00);
        // toggle then frequency output on module 2
        setv(2, 16'h0003);
        i_cpu.wr(ADDR_MODE[2], 8'h44);
        setc(16'h0000);
        ticks(10);
        chk(8'(pin[2]), 8'h01);
        setv(2, 16'h0402);
        i_cpu.wr(ADDR_MODE[2], 8'h46);
        setc(16'h0000);
        n = 0;
        p = pin[2];
        count_tick = 1'b1;
        repeat (64) begin
            @(negedge clk_sys);
            if (pin[2] !== p)
                n++;
            p = pin[2];
        end
        count_tick = 1'b0;
        chk(8'(n > 8), 8'h01);
        // pwm width against cycle length
        setc(16'h0270);
        setv(0, 16'h0080);
        for (int i = 0; i < 5; i++) begin
            i_cpu.wr(ADDR_PWM_CONFIG, pcfg[i]);
            i_cpu.wr(ADDR_MODE[0], pmode[i]);
            repeat (3) @(negedge clk_sys);
            chk(8'(pin[0]), 8'(ppin[i]));
        end
        // cycle wrap loads reload copy, or high byte in 8-bit cycles
        i_cpu.wr(ADDR_PWM_CONFIG, 8'h81);
        setv(0, 16'h0100);
        i_cpu.wr(ADDR_PWM_CONFIG, 8'h01);
        setc(16'h03ff);
        ticks(1);
        rchk(ADDR_VALUE_HIGH[0], 8'h01);
        i_cpu.wr(ADDR_PWM_CONFIG, 8'h00);
        setc(16'h00ff);
        ticks(1);
        rchk(ADDR_VALUE_LOW[0], 8'h01);
        wrap_up();
    end
endmodule : counter_array_module_mode_ctrl_tb

/* tb/counter_array_sva.sv */
// Purpose: port checks for the counter array mode control
// Assumes: a shadow of the mode registers follows port writes
// Notes: bound to the design top
`timescale 1ns/100ps
module counter_array_sva
    import counter_array_pkg::*;
#(
    parameter int NUM_MODULES = 3
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    // counter and module pins
    input wire logic count_tick,
    input wire logic [NUM_MODULES-1:0] capture_in,
    input wire logic [NUM_MODULES-1:0] module_output_pin,
    input wire logic [NUM_MODULES-1:0] event_flag_clr,
    input wire logic [NUM_MODULES-1:0] module_event_flag,
    input wire logic [NUM_MODULES-1:0] event_irq
);
    logic [7:0] mode_q [NUM_MODULES];
    logic [7:0] mode_d [NUM_MODULES];
    logic [NUM_MODULES-1:0] irq_en;
    logic [NUM_MODULES-1:0] act;
    logic [7:0] mode_rd;
    logic is_mode;

    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    // shadow of the mode registers
    always_comb begin
        mode_rd = 8'h00;
        is_mode = 1'b0;
        for (int k = 0; k < NUM_MODULES; k++) begin
            mode_d[k] = mode_q[k];
            irq_en[k] = mode_q[k][0];
            act[k] = mode_q[k][1] | mode_q[k][2];
            if (sfr_addr == ADDR_MODE[k]) begin
                mode_rd = mode_q[k];
                is_mode = 1'b1;
            end
            if (sfr_wr && sfr_addr == ADDR_MODE[k])
                mode_d[k] = sfr_wdata;
            if (sfr_wr && sfr_addr == ADDR_VALUE_LOW[k])
                mode_d[k][6] = 1'b0;
            if (sfr_wr && sfr_addr == ADDR_VALUE_HIGH[k])
                mode_d[k][6] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn)
            mode_q <= '{default: MODE_RESET};
        else
            mode_q <= mode_d;
    end

    a_irq_mask: assert property (
        event_irq == (module_event_flag & irq_en))
        else $error("irq differs from flag and enable");
    a_flag_hold: assert property (
        ((~module_event_flag) & $past(module_event_flag)
        & ~$past(event_flag_clr)) == '0)
        else $error("event flag dropped without clear");
    a_pin_static: assert property (
        ((module_output_pin ^ $past(module_output_pin))
        & ~(act | $past(act))) == '0) else $error("idle pin moved");
    a_cap_rise: assert property (
        $rose(capture_in[0]) && mode_q[0][5] |-> ##[1:4] module_event_flag[0])
        else $error("rising capture missed");
    a_cap_fall: assert property (
        $fell(capture_in[0]) && mode_q[0][4] |-> ##[1:4] module_event_flag[0])
        else $error("falling capture missed");
    a_mode_read: assert property (
        sfr_rd && is_mode |=> sfr_rdata == $past(mode_rd))
        else $error("mode readback wrong");
    a_low_read: assert property (
        sfr_wr && sfr_addr == ADDR_COUNTER_LOW ##1 !count_tick
        ##1 sfr_rd && sfr_addr == ADDR_COUNTER_LOW
        |=> sfr_rdata == $past(sfr_wdata, 3))
        else $error("counter low readback wrong");
    a_read_hold: assert property (
        $changed(sfr_rdata) |-> $past(sfr_rd))
        else $error("read data moved without read");
    a_unmapped: assert property (
        sfr_rd && sfr_addr == 8'h00 |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");

    c_match_irq: cover property (event_irq[1]);
    c_toggle: cover property ($rose(module_output_pin[2]));
    c_capture: cover property ($rose(module_event_flag[0]));
endmodule : counter_array_sva

bind counter_array_module_mode_ctrl counter_array_sva #(
    .NUM_MODULES(NUM_MODULES)
) i_sva (
    .clk_sys(clk_sys), .rstn(rstn), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .count_tick(count_tick),
    .capture_in(capture_in), .module_output_pin(module_output_pin),
    .event_flag_clr(event_flag_clr),
    .module_event_flag(module_event_flag), .event_irq(event_irq)
);

/* tb/cpu_sfr_model.sv */
// Purpose: cpu side of the register port
// Assumes: strobes last one cycle, driven at falling edges
// Notes: released address and data show the inverse of the last value
`timescale 1ns/100ps
module cpu_sfr_model (
    // clock
    input wire logic clk_sys,
    // register port
    output logic [7:0] sfr_addr,
    output logic sfr_wr,
    output logic sfr_rd,
    output logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata
);
    initial begin
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk_sys);
        sfr_wr = 1'b0;
        sfr_addr = ~a;
        sfr_wdata = ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clk_sys);
        d = sfr_rdata;
        sfr_rd = 1'b0;
        sfr_addr = ~a;
    endtask : rd
endmodule : cpu_sfr_model
